// *** src/ipv_pkg.sv ***
/*
 Constants, register map and helper functions of the prioritising interrupt
 controller and of the core end that acknowledges it.
 Assumes a single 50 MHz processor clock shared by both ends.
*/
package ipv_pkg;
   // Bus and field widths.
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 16;
   localparam int PAGE_W  = 4;
   localparam int LEVELS  = 14;
   localparam int LEVEL_W = 5;
   localparam int BASE_W  = 6;
   localparam int PIN_W   = 5;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets on the device bus.
   localparam logic [7:0] ADDR_LEVEL_MASK     = 8'h08;
   localparam logic [7:0] ADDR_TABLE_BASE     = 8'h09;
   localparam logic [7:0] ADDR_CORE_CONFIG    = 8'h0a;
   localparam logic [7:0] ADDR_CURRENT_VECTOR = 8'h0b;
   localparam logic [7:0] ADDR_SWI_SET        = 8'h0c;
   localparam logic [7:0] ADDR_SWI_CLEAR      = 8'h0d;

   // Field positions.
   localparam int CFG_SET_DISABLE_BIT = 4;
   localparam int CFG_DIS_STATUS_BIT  = 14;
   localparam int CFG_REQUEST_BIT     = 15;
   localparam int BASE_LSB            = 10;
   localparam int VEC_LEVEL_LSB       = 5;

   // Reset values and fixed masks.
   localparam logic [15:0] MASK_RST     = 16'h0000;
   localparam logic [15:0] MASK_VALID   = 16'h3ffe;
   localparam logic [5:0]  BASE_RST     = 6'h00;
   localparam logic        DISABLE_RST  = 1'b1;
   localparam logic [13:0] EDGE_LEVELS  = 14'h0381;
   localparam logic [4:0]  LEVEL_TOP    = 5'h0f;
   localparam logic [4:0]  LEVEL_NONE   = 5'h10;

   // Priorities of the sources; index equals priority.
   localparam int PRIO_NMI = 0;
   localparam int PRIO_T0  = 7;
   localparam int PRIO_SWI = 13;

   ////////////////////////////////////////////////////////////////////////////
   // Picks the highest priority (lowest index) pending level: {valid, prio}.
   function automatic logic [4:0] ipv_pick(input logic [13:0] pend);
      logic [4:0] res;
      res = 5'h00;
      for (int i = LEVELS - 1; i >= 0; i--)
      begin
         if (pend[i])
         begin
            res = {1'b1, 4'(i)};
         end
      end
      return res;
   endfunction : ipv_pick

   // Builds the vector from the table base and the picked level.
   function automatic logic [15:0] ipv_vector(input logic [5:0] base,
                                              input logic [4:0] pick);
      logic [4:0] lvl;
      lvl = pick[4] ? 5'(LEVEL_TOP - {1'b0, pick[3:0]}) : LEVEL_NONE;
      return {base, lvl, 5'h00};
   endfunction : ipv_vector
endpackage : ipv_pkg

// *** src/ipv_link_if.sv ***
/*
 Link between the interrupt controller and the processor core end.
 Assumes both ends run on the same clock; no clocking block.
*/
`timescale 1ns/10ps
`default_nettype none
interface ipv_link_if;
   logic        sample;
   logic        ack;
   logic        reenable;
   logic [7:0]  bus_addr;
   logic [15:0] bus_wdata;
   logic        bus_wr;
   logic        bus_rd;
   logic [15:0] bus_rdata;
   logic        irq_req;
   logic [15:0] vector;

   // Controller end.
   modport dev (input sample, ack, reenable, bus_addr, bus_wdata, bus_wr, bus_rd,
                output bus_rdata, irq_req, vector);
   // Core end.
   modport core (output sample, ack, reenable, bus_addr, bus_wdata, bus_wr, bus_rd,
                 input bus_rdata, irq_req, vector);
endinterface : ipv_link_if
`default_nettype wire

// *** src/ipv_controller.sv ***
/*
 Prioritising interrupt controller: synchronises pins, latches edge sources,
 samples per instruction, masks, arbitrates, builds the vector, and holds the
 mask, table base, configuration and fatal stack flags.
 Assumes the core end drives sample, ack and reenable as one-cycle pulses.
*/
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ipv_controller
   import ipv_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   ipv_link_if.dev                link,
   input  wire logic              nmi_i,
   input  wire logic [PIN_W-1:0]  ext_pins_i,
   input  wire logic [3:0]        stack_err_i,
   input  wire logic [2:0]        timer_i,
   input  wire logic              fatal_param_i,
   input  wire logic              fatal_ret_i,
   input  wire logic              sp_write_i,
   output logic                   int_disabled_o,
   output logic [1:0]             fatal_flags_o
);

   typedef struct packed {
      logic [PIN_W-1:0] pin_s1;
      logic [PIN_W-1:0] pin_s2;
      logic [PIN_W-1:0] pin_s3;
      logic [PIN_W-1:0] pin_f;
      logic             nmi_s1;
      logic             nmi_s2;
      logic             nmi_s3;
      logic             nmi_f;
      logic [2:0]       tmr_prev;
      logic [13:0]      edge_pend;
      logic [13:0]      sample;
      logic [1:0]       swi_pipe;
      logic             software_request;
      logic [15:0]      mask;
      logic [5:0]       base;
      logic [1:0]       fatal;
      logic             disable_irq;
      logic             req;
      logic [15:0]      vector;
      logic [15:0]      rdata;
   } ipv_dev_state_t;

   ipv_dev_state_t state_reg;
   ipv_dev_state_t state_next;

   // Pending levels after the mask; level 0 has no mask bit and always passes.
   function automatic logic [13:0] ipv_unmasked(input logic [13:0] pend,
                                                input logic [15:0] mask);
      return pend & ~{mask[13:1], 1'b0};
   endfunction : ipv_unmasked

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   always_comb
   begin
      logic [13:0] set_edge;
      logic [13:0] levels;
      logic [13:0] pend_now;
      logic [13:0] pend_next;
      logic [13:0] clr;
      logic [4:0]  pick_now;
      logic [4:0]  pick_next;
      logic        nmi_rise;
      logic [2:0]  tmr_rise;
      set_edge  = 14'h0000;
      levels    = 14'h0000;
      pend_now  = 14'h0000;
      pend_next = 14'h0000;
      clr       = 14'h0000;
      pick_now  = 5'h00;
      pick_next = 5'h00;
      nmi_rise  = 1'b0;
      tmr_rise  = 3'h0;
      state_next = state_reg;

      // Three-stage pin synchronisers; a change counts when stages 2 and 3 agree.
      state_next.pin_s1 = ext_pins_i;
      state_next.pin_s2 = state_reg.pin_s1;
      state_next.pin_s3 = state_reg.pin_s2;
      for (int i = 0; i < PIN_W; i++)
      begin
         if (state_reg.pin_s2[i] == state_reg.pin_s3[i])
         begin
            state_next.pin_f[i] = state_reg.pin_s2[i];
         end
      end
      state_next.nmi_s1 = nmi_i;
      state_next.nmi_s2 = state_reg.nmi_s1;
      state_next.nmi_s3 = state_reg.nmi_s2;
      if (state_reg.nmi_s2 == state_reg.nmi_s3)
      begin
         state_next.nmi_f = state_reg.nmi_s2;
      end
      nmi_rise = state_reg.nmi_s2 & state_reg.nmi_s3 & ~state_reg.nmi_f;

      // Timer edges come from logic on this clock and need no synchroniser.
      tmr_rise = timer_i & ~state_reg.tmr_prev;
      state_next.tmr_prev = timer_i;
      set_edge = {4'h0, tmr_rise, 6'h00, nmi_rise};

      // Acknowledge clears the winner only if it is an edge source.
      pend_now = ipv_unmasked(state_reg.sample, state_reg.mask);
      pick_now = ipv_pick(pend_now);
      if (link.ack && pick_now[4])
      begin
         clr = EDGE_LEVELS & (14'h0001 << pick_now[3:0]);
      end
      // A new edge wins over the clear of the same cycle.
      state_next.edge_pend = ((state_reg.edge_pend & ~clr) | set_edge) & EDGE_LEVELS;

      // Level sources in priority order.
      levels = {state_reg.swi_pipe[1], state_reg.pin_f[4:2], 3'h0,
                state_reg.pin_f[1], stack_err_i, state_reg.pin_f[0], 1'b0};

      // One sample per instruction; the core withholds it while streaming.
      if (link.sample)
      begin
         state_next.sample   = levels | (state_reg.edge_pend & ~clr);
         state_next.swi_pipe = {state_reg.swi_pipe[0], state_reg.software_request};
      end
      else
      begin
         state_next.sample = state_reg.sample & ~clr;
      end

      // Register writes.
      if (link.bus_wr)
      begin
         unique case (link.bus_addr)
            ADDR_LEVEL_MASK: state_next.mask = link.bus_wdata & MASK_VALID;
            ADDR_TABLE_BASE: state_next.base = link.bus_wdata[15:BASE_LSB];
            ADDR_CORE_CONFIG:
               state_next.disable_irq = link.bus_wdata[CFG_SET_DISABLE_BIT];
            ADDR_SWI_SET:    state_next.software_request = 1'b1;
            ADDR_SWI_CLEAR:  state_next.software_request = 1'b0;
            default:         state_next.software_request = state_reg.software_request;
         endcase
      end

      // Return re-enables; acknowledge disables and wins over both.
      if (link.reenable)
      begin
         state_next.disable_irq = 1'b0;
      end
      if (link.ack)
      begin
         state_next.disable_irq = 1'b1;
      end

      // Fatal flags: a new error wins over a stack pointer write.
      state_next.fatal = (sp_write_i ? 2'h0 : state_reg.fatal)
                       | {fatal_ret_i, fatal_param_i};

      // Arbitration on the next state keeps vector and request aligned.
      pend_next = ipv_unmasked(state_next.sample, state_next.mask);
      pick_next = ipv_pick(pend_next);
      state_next.vector = ipv_vector(state_next.base, pick_next);
      state_next.req = pend_next[PRIO_NMI]
                     | ((|pend_next[13:1]) & ~state_next.disable_irq);

      // Read data stands in the cycle after the read strobe only.
      state_next.rdata = 16'h0000;
      if (link.bus_rd)
      begin
         unique case (link.bus_addr)
            ADDR_LEVEL_MASK:     state_next.rdata = state_reg.mask;
            ADDR_TABLE_BASE:
               state_next.rdata = {state_reg.base, 9'h000, |state_reg.fatal};
            ADDR_CORE_CONFIG:
               state_next.rdata = {state_reg.req, state_reg.disable_irq, 14'h0000};
            ADDR_CURRENT_VECTOR: state_next.rdata = state_reg.vector;
            default:             state_next.rdata = 16'h0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register with synchronous reset.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg             <= '0;
         state_reg.mask        <= MASK_RST;
         state_reg.base        <= BASE_RST;
         state_reg.disable_irq <= DISABLE_RST;
         state_reg.vector      <= {BASE_RST, LEVEL_NONE, 5'h00};
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register.
   assign link.irq_req    = state_reg.req;
   assign link.vector     = state_reg.vector;
   assign link.bus_rdata  = state_reg.rdata;
   assign int_disabled_o  = state_reg.disable_irq;
   assign fatal_flags_o   = state_reg.fatal;

endmodule : ipv_controller
`default_nettype wire

// *** src/ipv_core_end.sv ***
/*
 Core end of the interrupt link: accepts requests at instruction boundaries,
 saves the return address and page, forces page zero, reads the vector and
 re-enables on a return from an interrupt-initiated call.
 Assumes the instruction sequencer pulses insn_i once per instruction.
*/
`timescale 1ns/10ps
`default_nettype none
module ipv_core_end
   import ipv_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   ipv_link_if.core               link,
   input  wire logic              insn_i,
   input  wire logic              streamed_i,
   input  wire logic [15:0]       pc_i,
   input  wire logic [PAGE_W-1:0] page_i,
   input  wire logic              page_load_i,
   input  wire logic              ret_i,
   input  wire logic [15:0]       ret_addr_i,
   input  wire logic [7:0]        bus_addr_i,
   input  wire logic [15:0]       bus_wdata_i,
   input  wire logic              bus_wr_i,
   input  wire logic              bus_rd_i,
   output logic [15:0]            bus_rdata_o,
   output logic                   acknowledge_o,
   output logic [15:0]            return_addr_o,
   output logic [PAGE_W-1:0]      saved_page_o,
   output logic [PAGE_W-1:0]      code_page_o,
   output logic [15:0]            handler_o
);

   typedef struct packed {
      logic              ack;
      logic              reenable;
      logic [15:0]       ret_addr;
      logic [PAGE_W-1:0] saved_page;
      logic [PAGE_W-1:0] code_page;
      logic [15:0]       handler;
   } ipv_core_state_t;

   ipv_core_state_t state_reg;
   ipv_core_state_t state_next;

   ////////////////////////////////////////////////////////////////////////////
   // Acceptance, save and return handling.
   always_comb
   begin
      state_next = state_reg;
      if (page_load_i)
      begin
         state_next.code_page = page_i;
      end
      // Accept at an instruction boundary outside streamed execution.
      state_next.ack = insn_i & ~streamed_i & link.irq_req & ~state_reg.ack;
      if (state_next.ack)
      begin
         state_next.ret_addr   = {pc_i[15:1], 1'b1};
         state_next.saved_page = page_i;
         state_next.code_page  = '0;
      end
      // The vector is read during the acknowledge cycle, whatever it holds.
      if (state_reg.ack)
      begin
         state_next.handler = link.vector;
      end
      state_next.reenable = ret_i & ret_addr_i[0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register with synchronous reset.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link drive; the register bus passes through unchanged.
   assign link.sample    = insn_i & ~streamed_i;
   assign link.ack       = state_reg.ack;
   assign link.reenable  = state_reg.reenable;
   assign link.bus_addr  = bus_addr_i;
   assign link.bus_wdata = bus_wdata_i;
   assign link.bus_wr    = bus_wr_i;
   assign link.bus_rd    = bus_rd_i;
   assign bus_rdata_o    = link.bus_rdata;
   assign acknowledge_o  = state_reg.ack;
   assign return_addr_o  = state_reg.ret_addr;
   assign saved_page_o   = state_reg.saved_page;
   assign code_page_o    = state_reg.code_page;
   assign handler_o      = state_reg.handler;

endmodule : ipv_core_end
`default_nettype wire

// *** bench/ipv_monitor.sv ***
/*
 Checker that watches the link between the interrupt controller and core end.
 Assumes one clock and a synchronous active-low reset shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module ipv_monitor
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        sample,
   input  wire logic        ack,
   input  wire logic        reenable,
   input  wire logic [7:0]  bus_addr,
   input  wire logic [15:0] bus_wdata,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   input  wire logic [15:0] bus_rdata,
   input  wire logic        irq_req,
   input  wire logic [15:0] vector
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   ////////////////////////////////////////////////////////////
   // Vector layout and its tie to the request line.
   vec_shape_a:
      assert property (vector[4:0] == 5'h00 && vector[9:5] inside {[5'h02:5'h10]})
      else $error("vector layout broken");
   req_level_a:
      assert property (irq_req |-> vector[9:5] != 5'h10)
      else $error("request without a level");
   nmi_req_a:
      assert property (vector[9:5] == 5'h0f |-> irq_req)
      else $error("nmi level without request");
   vec_hold_a:
      assert property (!sample && !ack && !bus_wr |=> $stable(vector))
      else $error("vector moved between samples");
   base_vec_a:
      assert property (bus_wr && bus_addr == 8'h09
         |=> {vector[15:10], 10'h000} == ($past(bus_wdata) & 16'hfc00))
      else $error("vector base not taken");

   ////////////////////////////////////////////////////////////
   // Read data timing and read-only configuration bits.
   rd_idle_a:
      assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
      else $error("read data outside its cycle");
   vec_read_a:
      assert property (bus_rd && bus_addr == 8'h0b |=> bus_rdata == $past(vector))
      else $error("vector read mismatch");
   cfg_read_a:
      assert property (bus_rd && bus_addr == 8'h0a
         |=> bus_rdata[13:0] == 14'h0000 && bus_rdata[15] == $past(irq_req))
      else $error("config read mismatch");

   ////////////////////////////////////////////////////////////
   // Acknowledge follows an accepted boundary and is a single pulse.
   ack_cause_a:
      assert property (ack |-> $past(sample) && $past(irq_req))
      else $error("acknowledge without cause");
   ack_single_a:
      assert property (ack |=> !ack)
      else $error("acknowledge too long");

   // Main scenarios reached.
   cover property (ack);
   cover property (reenable);
   cover property (irq_req && vector[9:5] == 5'h0f);
   cover property (bus_rd && bus_addr == 8'h0b);
endmodule : ipv_monitor
`default_nettype wire

// *** bench/tb_top.sv ***
/*
 Self-checking bench: controller and core end joined by their link.
 Assumes the package, the link interface and the monitor compile first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import ipv_pkg::*;
   ;
   logic        clk_i   = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        nmi = 1'b0, insn = 1'b0, strm = 1'b0, pload = 1'b0, ret = 1'b0;
   logic        wr = 1'b0, rd = 1'b0, fp = 1'b0, fr = 1'b0, spw = 1'b0;
   logic [4:0]  pins = 5'h00;
   logic [3:0]  serr = 4'h0, pg = 4'h0, spg, cpg;
   logic [2:0]  tmr = 3'h0;
   logic [7:0]  addr = 8'h00;
   logic [15:0] pc = 16'h0000, raddr = 16'h0000, wd = 16'h0000;
   logic [15:0] rdo, ra, hd, v, m, lf = 16'h55f9;
   logic        dis, ackd;
   logic [1:0]  ff;
   int          miscompares = 0, comparisons = 0, nack = 0;

   // Clock, and a count of acknowledge pulses seen at the core end.
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i)
      if (ackd) nack++;

   ipv_link_if u_link ();
   ipv_controller u_ipv_controller (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(u_link),
      .nmi_i(nmi), .ext_pins_i(pins), .stack_err_i(serr), .timer_i(tmr),
      .fatal_param_i(fp), .fatal_ret_i(fr), .sp_write_i(spw),
      .int_disabled_o(dis), .fatal_flags_o(ff));
   ipv_core_end u_ipv_core_end (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(u_link),
      .insn_i(insn), .streamed_i(strm), .pc_i(pc), .page_i(pg), .page_load_i(pload),
      .ret_i(ret), .ret_addr_i(raddr), .bus_addr_i(addr), .bus_wdata_i(wd),
      .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdo), .acknowledge_o(ackd),
      .return_addr_o(ra), .saved_page_o(spg), .code_page_o(cpg), .handler_o(hd));
   ipv_monitor u_ipv_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .sample(u_link.sample), .ack(u_link.ack), .reenable(u_link.reenable),
      .bus_addr(u_link.bus_addr), .bus_wdata(u_link.bus_wdata), .bus_wr(u_link.bus_wr),
      .bus_rd(u_link.bus_rd), .bus_rdata(u_link.bus_rdata), .irq_req(u_link.irq_req),
      .vector(u_link.vector));

   ////////////////////////////////////////////////////////////
   // Random source and the expected vector for a pending set, base 2000h.
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nxt
   function automatic logic [15:0] ev(input logic [13:0] p);
      logic [4:0] l;
      l = 5'h10;
      for (int i = 13; i >= 0; i--)
         if (p[i])
            l = 5'(15 - i);
      // Slots sit 32 bytes apart above an aligned table base.
      return {6'h08, l, 5'h00};
   endfunction : ev

   // Comparison, bus cycles, instruction boundary and return.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
      comparisons++;
      if (got !== exp)
      begin
         miscompares++;
         $display("BAD %s at %0t got %h exp %h", s, $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc
   task automatic bw(input logic [7:0] a, input logic [15:0] d);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      @(posedge clk_i);
   endtask : bw
   task automatic rc(input logic [7:0] a, input logic [15:0] e, input string s);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      @(posedge clk_i);
      v = rdo;
      chk(v, e, s);
   endtask : rc
   task automatic samp;
      insn <= 1'b1;
      @(posedge clk_i);
      insn <= 1'b0;
      cyc(2);
   endtask : samp
   task automatic rt(input logic [15:0] a);
      raddr <= a;
      ret <= 1'b1;
      @(posedge clk_i);
      ret <= 1'b0;
      cyc(2);
   endtask : rt
   task automatic summarize;
      $display("counts: %0d compared, %0d wrong", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////
   // Cuts a hung run short.
   initial
   begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      summarize();
   end

   // Main sequence.
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      rc(8'h08, 16'h0000, "mask");
      rc(8'h0a, 16'h4000, "config");
      rc(8'h0b, 16'h0200, "vector");
      rc(8'h3f, 16'h0000, "unmapped");
      bw(8'h0b, 16'hffff);
      bw(8'h09, 16'h2000);
      rc(8'h0b, 16'h2200, "vector");
      $display("reset test done");
      // Random levels and mask; first pass masks all, second masks none.
      for (int k = 0; k < 40; k++)
      begin
         lf = nxt(lf);
         pins <= lf[4:0];
         serr <= lf[8:5];
         lf = nxt(lf);
         m = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : lf;
         bw(8'h08, m);
         cyc(3);
         samp();
         rc(8'h08, m & 16'h3ffe, "mask");
         rc(8'h0b, ev({1'b0, pins[4:2], 3'h0, pins[1], serr, pins[0], 1'b0}
            & ~m[13:0]), "vector");
      end
      $display("priority test done");
      // Clear sources, then enable by reading config and writing it back.
      pins <= 5'h00;
      serr <= 4'h0;
      bw(8'h08, 16'h0000);
      cyc(3);
      samp();
      rc(8'h0a, 16'h4000, "config");
      bw(8'h0a, v);
      chk(16'(dis), 16'h0000, "disable");
      // Two timers at once; streamed boundaries are ignored.
      tmr <= 3'h3;
      @(posedge clk_i);
      tmr <= 3'h0;
      samp();
      rc(8'h0a, 16'h8000, "config");
      strm <= 1'b1;
      samp();
      strm <= 1'b0;
      chk(16'(nack), 16'h0000, "acks");
      lf = nxt(lf);
      pc <= lf;
      pg <= 4'h5;
      pload <= 1'b1;
      @(posedge clk_i);
      pload <= 1'b0;
      samp();
      chk(16'(nack), 16'h0001, "acks");
      chk(hd, 16'h2100, "handler");
      chk(ra, pc | 16'h0001, "return");
      chk({8'h00, spg, cpg}, 16'h0050, "pages");
      chk(16'(dis), 16'h0001, "disable");
      rc(8'h0b, 16'h20e0, "vector");
      rt(16'h1234);
      chk(16'(dis), 16'h0001, "disable");
      rt(16'h1235);
      chk(16'(dis), 16'h0000, "disable");
      cyc(1);
      samp();
      chk(hd, 16'h20e0, "handler");
      chk(16'(nack), 16'h0002, "acks");
      $display("acknowledge test done");
      // Non-maskable level with everything masked and disabled.
      rt(16'h0001);
      bw(8'h0a, 16'h0010);
      chk(16'(dis), 16'h0001, "disable");
      bw(8'h08, 16'hffff);
      nmi <= 1'b1;
      cyc(4);
      samp();
      rc(8'h0b, 16'h21e0, "vector");
      samp();
      chk(hd, 16'h21e0, "handler");
      nmi <= 1'b0;
      samp();
      rc(8'h0b, 16'h2200, "vector");
      $display("nmi test done");
      // Software request seen only on the third boundary, then cleared.
      bw(8'h08, 16'h0000);
      bw(8'h0c, 16'h0000);
      samp();
      samp();
      rc(8'h0b, 16'h2200, "vector");
      samp();
      rc(8'h0b, 16'h2040, "vector");
      bw(8'h0d, 16'h0000);
      repeat (3) samp();
      rc(8'h0b, 16'h2200, "vector");
      $display("software test done");
      // Fatal stack flags: set, cleared by a pointer write, new error wins.
      fp <= 1'b1;
      @(posedge clk_i);
      fp <= 1'b0;
      rc(8'h09, 16'h2001, "base");
      spw <= 1'b1;
      fr <= 1'b1;
      @(posedge clk_i);
      spw <= 1'b0;
      fr <= 1'b0;
      rc(8'h0b, 16'h2200, "vector");
      chk({14'h0000, ff}, 16'h0002, "fatal");
      spw <= 1'b1;
      @(posedge clk_i);
      spw <= 1'b0;
      rc(8'h09, 16'h2000, "base");
      $display("fatal test done");
      // A level that drops before the acknowledge yields the no-interrupt vector.
      bw(8'h0a, 16'h0000);
      serr <= 4'h1;
      samp();
      rc(8'h0b, 16'h21a0, "vector");
      serr <= 4'h0;
      samp();
      chk(hd, 16'h2200, "handler");
      chk(16'(nack), 16'h0004, "acks");
      chk(16'(dis), 16'h0001, "disable");
      $display("dropped request test done");
      summarize();
   end
endmodule : tb_top
`default_nettype wire
